// file: verilog/ipm_pkg.sv
/*
  Shared constants and carrier types for the incremental PID compensator.
  Assumes a single 125 MHz clock and signed 16-bit fixed-point operands.
*/
`default_nettype none
package ipm_pkg;
  localparam int DATA_W    = 16;
  localparam int ACC_W     = 40;
  localparam int COEF_FRAC = 12;
  localparam int CLK_MHZ   = 125;
  // Loop time budget in ns and derived cycle count (longest time, rounded down).
  localparam int LOOP_NS     = 2000;
  localparam int LOOP_CYCLES = (LOOP_NS * CLK_MHZ) / 1000;
  localparam logic [DATA_W-1:0] OUT_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] ERR_RESET = 16'h0000;
  localparam logic [ACC_W-1:0]  ACC_RESET = 40'h00_0000_0000;

  typedef struct packed {
    logic signed [DATA_W-1:0] proportional_gain;
    logic signed [DATA_W-1:0] integral_gain;
    logic signed [DATA_W-1:0] derivative_gain;
  } ipm_gains_t;

  typedef struct packed {
    logic signed [DATA_W-1:0] lower;
    logic signed [DATA_W-1:0] upper;
    logic        [DATA_W-1:0] period;
  } ipm_limits_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ERR   = 3'b001,
    ST_MAC0  = 3'b011,
    ST_MAC1  = 3'b010,
    ST_MAC2  = 3'b110,
    ST_CLAMP = 3'b111,
    ST_WAIT  = 3'b101
  } ipm_state_t;
endpackage : ipm_pkg
`default_nettype wire

// file: verilog/ipm_loop.sv
/*
  Incremental PID loop: error formation, three-step MAC over two operand banks,
  range check and PWM duty clamp, at most one update per PWM period.
  Assumes SAMPLE_VALID and PERIOD_START come from logic on MCLK, and that gains
  are in signed Q3.12 with T already folded in (k_i*T and k_d/T).
*/
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1: error is reference minus measured feedback
// RULE2: coefficients derived from gains and period
// RULE3: output adds weighted current and prior errors
// RULE4: signed 16x16 products into 40-bit accumulator
// RULE5: each MAC step multiplies, accumulates, reloads, advances
// RULE6: two operand banks with separate address generators
// RULE7: whole computation finishes within two microseconds
// RULE8: new output checked against configured range
// RULE9: at most one update per PWM period
// RULE10: duty written, never exceeding PWM period
// RULE11: reset clears history; accumulator seeded each computation
module ipm_loop (
  // Clock and reset
  input  wire logic                MCLK,
  input  wire logic                RESET,
  // Feedback sample and reference
  input  wire logic                SAMPLE_VALID,
  input  wire logic signed [15:0]  FEEDBACK,
  input  wire logic signed [15:0]  REFERENCE,
  // Configuration
  input  wire ipm_pkg::ipm_gains_t  GAINS,
  input  wire ipm_pkg::ipm_limits_t LIMITS,
  // PWM side
  input  wire logic                PERIOD_START,
  output logic             [15:0]  DUTY,
  output logic                     DUTY_VALID,
  output logic                     RANGE_FAULT,
  output logic                     BUSY
);
  ipm_pkg::ipm_state_t state;
  logic signed [15:0] coef_bank [0:2];
  logic signed [15:0] err_bank  [0:2];
  logic        [1:0]  coef_ptr;
  logic        [1:0]  err_ptr;
  logic signed [15:0] coef_op;
  logic signed [15:0] err_op;
  logic signed [39:0] acc;
  logic signed [15:0] prev_out;
  logic               updated_this_period;
  logic signed [15:0] latched_fb;
  logic               pending;

  // Full-precision product; the Q3.12 fraction is dropped once, after the last step,
  // so truncation does not build up across the three terms.
  function automatic logic signed [39:0] mac_term(input logic signed [15:0] a,
                                                  input logic signed [15:0] b);
    logic signed [31:0] p;
    p = a * b;
    mac_term = 40'(p);
  endfunction : mac_term

  function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
    if (v > 40'sh00_0000_7fff)
      sat16 = 16'sh7fff;
    else if (v < -40'sh00_0000_8000)
      sat16 = -16'sh8000;
    else
      sat16 = v[15:0];
  endfunction : sat16

  // Coefficients follow the gains while idle and hold during a computation; a change takes effect next sample.
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      coef_bank[0] <= ipm_pkg::ERR_RESET;
      coef_bank[1] <= ipm_pkg::ERR_RESET;
      coef_bank[2] <= ipm_pkg::ERR_RESET;
    end else if (state == ipm_pkg::ST_IDLE) begin
      coef_bank[0] <= 16'(GAINS.proportional_gain + GAINS.integral_gain
                          + GAINS.derivative_gain); // RULE2
      coef_bank[1] <= 16'(-(GAINS.proportional_gain
                            + (GAINS.derivative_gain <<< 1))); // RULE2
      coef_bank[2] <= GAINS.derivative_gain; // RULE2
    end
  end

  // A sample arriving mid-computation is held, not lost; the newest one wins.
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      pending    <= 1'b0;
      latched_fb <= ipm_pkg::ERR_RESET;
    end else if (SAMPLE_VALID) begin
      pending    <= 1'b1;
      latched_fb <= FEEDBACK;
    end else if (state == ipm_pkg::ST_IDLE && pending && !updated_this_period
                 && !PERIOD_START) begin
      pending <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    // An update finishing on a period start lands in the new period, so the set wins.
    if (RESET)
      updated_this_period <= 1'b0;
    else if (state == ipm_pkg::ST_CLAMP)
      updated_this_period <= 1'b1; // RULE9
    else if (PERIOD_START)
      updated_this_period <= 1'b0;
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET)
      state <= ipm_pkg::ST_IDLE;
    else
      case (state)
        ipm_pkg::ST_IDLE:
          if (pending && !updated_this_period && !PERIOD_START)
            state <= ipm_pkg::ST_ERR; // RULE9
        ipm_pkg::ST_ERR:   state <= ipm_pkg::ST_MAC0;
        ipm_pkg::ST_MAC0:  state <= ipm_pkg::ST_MAC1;
        ipm_pkg::ST_MAC1:  state <= ipm_pkg::ST_MAC2;
        ipm_pkg::ST_MAC2:  state <= ipm_pkg::ST_CLAMP;
        ipm_pkg::ST_CLAMP: state <= ipm_pkg::ST_IDLE;
        default:           state <= ipm_pkg::ST_IDLE;
      endcase
  end

  // Error history: slot 0 newest. Shifted once per computation, in ST_CLAMP after the MACs.
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      err_bank[0] <= ipm_pkg::ERR_RESET; // RULE11
      err_bank[1] <= ipm_pkg::ERR_RESET; // RULE11
      err_bank[2] <= ipm_pkg::ERR_RESET; // RULE11
    end else if (state == ipm_pkg::ST_ERR) begin
      err_bank[0] <= sat16(40'(REFERENCE) - 40'(latched_fb)); // RULE1
    end else if (state == ipm_pkg::ST_CLAMP) begin
      err_bank[2] <= err_bank[1];
      err_bank[1] <= err_bank[0];
    end
  end

  // Two banks, each with its own pointer and read port, fetched in the same cycle.
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      coef_ptr <= 2'h0;
      err_ptr  <= 2'h0;
      coef_op  <= ipm_pkg::ERR_RESET;
      err_op   <= ipm_pkg::ERR_RESET;
    end else if (state == ipm_pkg::ST_ERR) begin
      coef_ptr <= 2'h1;
      err_ptr  <= 2'h1;
      coef_op  <= coef_bank[0];
      err_op   <= sat16(40'(REFERENCE) - 40'(latched_fb)); // RULE1
    end else if (state == ipm_pkg::ST_MAC0 || state == ipm_pkg::ST_MAC1) begin
      coef_op  <= coef_bank[coef_ptr]; // RULE6
      err_op   <= err_bank[err_ptr]; // RULE6
      coef_ptr <= coef_ptr + 2'h1; // RULE5
      err_ptr  <= err_ptr + 2'h1; // RULE5
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET)
      acc <= ipm_pkg::ACC_RESET;
    else if (state == ipm_pkg::ST_ERR)
      acc <= 40'(prev_out) <<< ipm_pkg::COEF_FRAC; // RULE11
    else if (state == ipm_pkg::ST_MAC0 || state == ipm_pkg::ST_MAC1
             || state == ipm_pkg::ST_MAC2)
      acc <= acc + mac_term(coef_op, err_op); // RULE3 RULE4 RULE5
  end

  // Clamp both to the configured range and to the PWM period.
  // The range test sees the unsaturated sum, so an overflow past a limit is flagged.
  logic signed [39:0] whole;
  logic signed [15:0] ranged;
  logic               out_of_range;
  always_comb begin
    whole        = acc >>> ipm_pkg::COEF_FRAC;
    ranged       = sat16(whole);
    out_of_range = 1'b0;
    if (whole > 40'(LIMITS.upper)) begin
      ranged       = LIMITS.upper; // RULE8
      out_of_range = 1'b1;
    end else if (whole < 40'(LIMITS.lower)) begin
      ranged       = LIMITS.lower; // RULE8
      out_of_range = 1'b1;
    end
    if (ranged < 16'sh0000)
      ranged = 16'sh0000;
    if ($unsigned(ranged) > LIMITS.period)
      ranged = $signed(LIMITS.period); // RULE10
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      prev_out    <= ipm_pkg::OUT_RESET; // RULE11
      DUTY        <= ipm_pkg::OUT_RESET;
      DUTY_VALID  <= 1'b0;
      RANGE_FAULT <= 1'b0;
    end else begin
      DUTY_VALID <= (state == ipm_pkg::ST_CLAMP);
      if (state == ipm_pkg::ST_CLAMP) begin
        prev_out    <= ranged;
        DUTY        <= ranged; // RULE10
        RANGE_FAULT <= out_of_range; // RULE8
      end
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET)
      BUSY <= 1'b0;
    else
      BUSY <= (state != ipm_pkg::ST_IDLE) && (state != ipm_pkg::ST_CLAMP);
  end

  // Helper: cycles since a computation began.
  logic [15:0] run_cnt;
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET)
      run_cnt <= 16'h0000;
    else if (state == ipm_pkg::ST_IDLE)
      run_cnt <= 16'h0000;
    else
      run_cnt <= run_cnt + 16'h0001;
  end

  // Helper: an update was shown in this PWM period. An update on the period start
  // still belongs to the period that ends, so the clear wins here.
  logic upd_seen;
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET)
      upd_seen <= 1'b0;
    else if (PERIOD_START)
      upd_seen <= 1'b0;
    else if (DUTY_VALID)
      upd_seen <= 1'b1;
  end

  loop_budget_a: assert property (@(posedge MCLK) disable iff (RESET) // RULE7
    run_cnt < 16'(ipm_pkg::LOOP_CYCLES)) else $error("loop exceeded time budget");
  five_cycle_a: assert property (@(posedge MCLK) disable iff (RESET) // RULE5
    state == ipm_pkg::ST_ERR |-> ##4 state == ipm_pkg::ST_CLAMP ##1 DUTY_VALID)
    else $error("computation did not take five cycles");
  duty_period_a: assert property (@(posedge MCLK) disable iff (RESET) // RULE10
    DUTY_VALID |-> DUTY <= LIMITS.period) else $error("duty above period");
  one_update_a: assert property (@(posedge MCLK) disable iff (RESET) // RULE9
    DUTY_VALID |-> !upd_seen)
    else $error("second update within one period");
  seed_acc_a: assert property (@(posedge MCLK) disable iff (RESET) // RULE11
    state == ipm_pkg::ST_ERR |=> acc == (40'($past(prev_out)) <<< ipm_pkg::COEF_FRAC))
    else $error("accumulator not seeded from previous output");
  error_form_a: assert property (@(posedge MCLK) disable iff (RESET) // RULE1
    state == ipm_pkg::ST_ERR && !$past(SAMPLE_VALID) |=>
      err_bank[0] == sat16(40'($past(REFERENCE)) - 40'($past(latched_fb))))
    else $error("error is not reference minus feedback");
  dual_fetch_a: assert property (@(posedge MCLK) disable iff (RESET) // RULE6
    state == ipm_pkg::ST_MAC0 |=> coef_op == $past(coef_bank[1])
      && err_op == $past(err_bank[1])) else $error("dual fetch wrong operands");
  range_flag_a: assert property (@(posedge MCLK) disable iff (RESET) // RULE8
    DUTY_VALID && !RANGE_FAULT |-> $signed(DUTY) <= LIMITS.upper)
    else $error("range check missed");
endmodule : ipm_loop
`default_nettype wire

// file: dv/ipm_partner.sv
/*
  Far-side model: PWM period counter and converter sample strobe.
  Assumes clock and reset from the bench, which also supplies FEEDBACK values.
*/
`timescale 1ns/1ps
`default_nettype none
module ipm_partner #(
  parameter int PER = 40
) (
  // Clock, reset and mode
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic dbl,
  // Strobes to the loop
  output logic      period_start,
  output logic      sample_valid
);
  int cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt          <= 0;
      period_start <= 1'b0;
      sample_valid <= 1'b0;
    end else begin
      cnt          <= (cnt == PER - 1) ? 0 : cnt + 1;
      period_start <= (cnt == PER - 1);
      // Double-rate mode sends a late second sample in the same period that must wait a period.
      sample_valid <= dbl ? (cnt == 9 || cnt == 19) : (cnt == 1);
    end
  end
endmodule : ipm_partner
`default_nettype wire

// file: dv/tb_top.sv
/*
  Self-checking bench for the PID loop with an integer reference model.
  Assumes the partner model drives the period and sample strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int PER = 40;
  logic                MCLK, RESET, SAMPLE_VALID, PERIOD_START, dbl;
  logic signed [15:0]  FEEDBACK, REFERENCE;
  ipm_pkg::ipm_gains_t  GAINS;
  ipm_pkg::ipm_limits_t LIMITS;
  logic        [15:0]  DUTY;
  logic                DUTY_VALID, RANGE_FAULT, BUSY, busy_d;
  int                  seed, fails, n_tests, ph, uprev, e0, e1, e2, fb_q, lat, nupd;
  int                  fb_d, ref_d, ntot;

  ipm_loop DUT (.MCLK(MCLK), .RESET(RESET), .SAMPLE_VALID(SAMPLE_VALID),
    .FEEDBACK(FEEDBACK), .REFERENCE(REFERENCE), .GAINS(GAINS), .LIMITS(LIMITS),
    .PERIOD_START(PERIOD_START), .DUTY(DUTY), .DUTY_VALID(DUTY_VALID),
    .RANGE_FAULT(RANGE_FAULT), .BUSY(BUSY));
  ipm_partner #(.PER(PER)) u_par (.clk(MCLK), .rst(RESET), .dbl(dbl),
    .period_start(PERIOD_START), .sample_valid(SAMPLE_VALID));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end

  // Operands change only at period starts so every sample in a period agrees.
  always @(posedge MCLK) if (u_par.cnt == PER - 1) begin
    GAINS.proportional_gain <= (ph == 2) ? 16'($random(seed)) : 16'($random(seed) % 2048);
    GAINS.integral_gain     <= (ph == 2) ? 16'($random(seed)) : 16'($random(seed) % 1024);
    GAINS.derivative_gain   <= (ph == 2) ? 16'($random(seed)) : 16'($random(seed) % 512);
    REFERENCE <= (ph == 3) ? {ph[0], {15{~ph[0]}}} : 16'($random(seed) % 600);
    FEEDBACK  <= (ph == 3) ? {~ph[0], {15{ph[0]}}} : 16'($random(seed) % 600);
    if (ph == 1) LIMITS <= '{lower: 16'sd100, upper: 16'sd300, period: 16'd1000};
    else if (ph >= 2 && ph <= 3) LIMITS <= '{lower: -16'sd32768, upper: 16'sd32767, period: 16'd500};
    else LIMITS <= '{lower: -16'sd200, upper: 16'sd4000, period: 16'd3000};
  end

  always @(posedge MCLK) begin : model
    int  u;
    bit  flt;
    shortint ca, cb, cc;
    longint  acc;
    if (RESET) begin
      uprev = 0; e1 = 0; e2 = 0; nupd = 0; busy_d = 0;
    end else begin
      if (BUSY && !busy_d) begin
        e0  = ref_d - fb_d;
        e0  = (e0 > 32767) ? 32767 : (e0 < -32768) ? -32768 : e0;
        lat = 0;
      end
      lat++;
      // The loop takes its operands one edge before BUSY shows, so the model lags too.
      ref_d = int'(REFERENCE);
      fb_d  = fb_q;
      if (SAMPLE_VALID) fb_q = int'(FEEDBACK);
      if (DUTY_VALID) begin
        ca  = shortint'(GAINS.proportional_gain + GAINS.integral_gain + GAINS.derivative_gain);
        cb  = shortint'(-(GAINS.proportional_gain + 2 * GAINS.derivative_gain));
        cc  = GAINS.derivative_gain;
        acc = longint'(ca) * e0 + longint'(cb) * e1 + longint'(cc) * e2;
        u   = uprev + int'(acc >>> 12);
        flt = (u < int'(LIMITS.lower)) || (u > int'(LIMITS.upper));
        u   = (u < int'(LIMITS.lower)) ? int'(LIMITS.lower) : u;
        u   = (u > int'(LIMITS.upper)) ? int'(LIMITS.upper) : u;
        u   = (u < 0) ? 0 : (u > int'(LIMITS.period)) ? int'(LIMITS.period) : u;
        check(64'(DUTY), 64'(u));
        check(64'(RANGE_FAULT), 64'(flt));
        check(64'(lat <= ipm_pkg::LOOP_CYCLES), 64'h1);
        check(64'(BUSY), 64'h0);
        uprev = u; e2 = e1; e1 = e0;
        nupd++;
        ntot++;
      end
      if (PERIOD_START) begin
        check(64'(nupd > 1), 64'h0);
        nupd = 0;
      end
      busy_d = BUSY;
    end
  end

  initial begin
    seed = 32'h668dede1;
    RESET = 1'b1; dbl = 1'b0; ph = 0; FEEDBACK = 16'h0000; REFERENCE = 16'h0000;
    GAINS = '0; LIMITS = '{lower: -16'sd200, upper: 16'sd4000, period: 16'd3000};
    repeat (16) @(posedge MCLK);
    RESET <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      ph <= i;
      dbl <= (i == 4);
      if (i == 5) begin
        repeat (7) @(posedge MCLK);
        RESET <= 1'b1;
        repeat (16) @(posedge MCLK);
        RESET <= 1'b0;
        @(posedge MCLK);
        check(64'(DUTY), 64'h0);
      end
      repeat (12 * PER) @(posedge MCLK);
    end
    check(64'(ntot >= 40), 64'h1);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge MCLK);
    fails++;
    summarize();
  end
endmodule : tb_top
`default_nettype wire
